// >>> hw/scs_sensor_channel_select.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - After reset the radio channel is the preset default of 35.
// - Pressing and holding the button from idle gives one quick entry flash.
// - Holding the button in the first phase flashes and counts; release latches the tens digit.
// - Releasing before any counting flash gives a tens digit of zero.
// - The next press after the tens digit gives two quick flashes to open the units phase.
// - Holding in the units phase counts; release sets the channel and gives two quick flashes.
// - On error the light stays on about two seconds and the old channel is kept.
// - In normal operation a report is sent on the chosen channel every few minutes.
module scs_sensor_channel_select #(
    parameter longint FLASH_CYC = scs_pkg::FLASH_PERIOD_CYC,
    parameter longint QUICK_CYC = scs_pkg::QUICK_ON_CYC,
    parameter longint ERROR_CYC = scs_pkg::ERROR_ON_CYC,
    parameter longint REPORT_CYC = scs_pkg::REPORT_CYC,
    parameter longint TIMEOUT_CYC = scs_pkg::ERROR_ON_CYC * 5
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_button,
    output logic o_light,
    output logic [6:0] o_channel,
    output logic o_report
);
    localparam int W = scs_pkg::CNT_W;
    localparam logic [W-1:0] FLASH_LAST = W'(FLASH_CYC - 1);
    localparam logic [W-1:0] REPORT_LAST = W'(REPORT_CYC - 1);
    localparam logic [W-1:0] TIMEOUT_LAST = W'(TIMEOUT_CYC - 1);

    scs_light_if lif ();
    scs_pkg::scs_state_type state_reg;
    logic btn_meta_reg;
    logic btn_reg;
    logic [W-1:0] tick_reg;
    logic [W-1:0] rep_reg;
    logic [3:0] count_reg;
    logic [3:0] tens_reg;
    logic over_reg;
    logic start_reg;
    logic [1:0] flashes_reg;
    logic hold_reg;

    // =========================================================
    // Button input
    // =========================================================
    // The button is a pin, so it is resynchronised before use.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            btn_meta_reg <= 1'b0;
            btn_reg <= 1'b0;
        end else if (i_ce) begin
            btn_meta_reg <= i_button;
            btn_reg <= btn_meta_reg;
        end
    end

    // =========================================================
    // Sequencer
    // =========================================================
    // Tick counter paces counting flashes; it also times out a forgotten second press.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= scs_pkg::SCS_IDLE;
            tick_reg <= '0;
            count_reg <= 4'h0;
            tens_reg <= 4'h0;
            over_reg <= 1'b0;
            o_channel <= scs_pkg::CHAN_RESET;
            start_reg <= 1'b0;
            flashes_reg <= 2'h0;
            hold_reg <= 1'b0;
        end else if (i_ce) begin
            start_reg <= 1'b0;
            tick_reg <= tick_reg + 1'b1;
            case (state_reg)
                scs_pkg::SCS_IDLE: begin
                    tick_reg <= '0;
                    if (btn_reg && !lif.busy) begin
                        start_reg <= 1'b1;
                        flashes_reg <= 2'h1;
                        hold_reg <= 1'b0;
                        count_reg <= 4'h0;
                        over_reg <= 1'b0;
                        state_reg <= scs_pkg::SCS_TENS;
                    end
                end
                scs_pkg::SCS_TENS, scs_pkg::SCS_UNITS: begin
                    if (!btn_reg) begin
                        tick_reg <= '0;
                        if (over_reg) begin
                            start_reg <= 1'b1;
                            hold_reg <= 1'b1;
                            state_reg <= scs_pkg::SCS_ERROR;
                        end else if (state_reg == scs_pkg::SCS_TENS) begin
                            tens_reg <= count_reg;
                            state_reg <= scs_pkg::SCS_WAIT2;
                        end else begin
                            // Both digits are known; the new channel takes effect now.
                            // Widen before the product so tens of up to nine cannot wrap.
                            o_channel <= 7'(tens_reg) * 7'hA + 7'(count_reg);
                            start_reg <= 1'b1;
                            flashes_reg <= 2'h2;
                            hold_reg <= 1'b0;
                            state_reg <= scs_pkg::SCS_CONFIRM;
                        end
                    end else if (tick_reg == FLASH_LAST) begin
                        // A digit above nine is remembered and rejected on release.
                        tick_reg <= '0;
                        start_reg <= 1'b1;
                        flashes_reg <= 2'h1;
                        hold_reg <= 1'b0;
                        if (count_reg == scs_pkg::DIGIT_MAX) begin
                            over_reg <= 1'b1;
                        end else begin
                            count_reg <= count_reg + 4'h1;
                        end
                    end
                end
                scs_pkg::SCS_WAIT2: begin
                    if (btn_reg) begin
                        start_reg <= 1'b1;
                        flashes_reg <= 2'h2;
                        hold_reg <= 1'b0;
                        count_reg <= 4'h0;
                        tick_reg <= '0;
                        state_reg <= scs_pkg::SCS_GAP2;
                    end else if (tick_reg == TIMEOUT_LAST) begin
                        start_reg <= 1'b1;
                        hold_reg <= 1'b1;
                        state_reg <= scs_pkg::SCS_ERROR;
                    end
                end
                scs_pkg::SCS_GAP2: begin
                    // The double flash must not be counted as a units flash.
                    tick_reg <= '0;
                    state_reg <= scs_pkg::SCS_UNITS;
                end
                default: begin
                    // Confirm and error patterns finish before a new entry is taken.
                    tick_reg <= '0;
                    if (!lif.busy && !btn_reg) begin
                        state_reg <= scs_pkg::SCS_IDLE;
                    end
                end
            endcase
        end
    end

    assign lif.start = start_reg;
    assign lif.flashes = flashes_reg;
    assign lif.hold_on = hold_reg;

    scs_light_gen #(
        .QUICK_CYC(QUICK_CYC),
        .LONG_CYC(ERROR_CYC)
    ) u_light (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .lif(lif),
        .o_light(o_light)
    );

    // =========================================================
    // Periodic report
    // =========================================================
    // Reports pause while the channel is being changed so none goes out on a half-set channel.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rep_reg <= '0;
            o_report <= 1'b0;
        end else if (i_ce) begin
            o_report <= 1'b0;
            if (state_reg == scs_pkg::SCS_IDLE) begin
                if (rep_reg == REPORT_LAST) begin
                    rep_reg <= '0;
                    o_report <= 1'b1;
                end else begin
                    rep_reg <= rep_reg + 1'b1;
                end
            end
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    // An error request is a steady-light start while the clock enable lets it through.
    sequence s_error_request;
        i_ce && start_reg && hold_reg;
    endsequence

    // The light must then stay on for eight cycles in a row.
    sequence s_light_steady;
        o_light [*8];
    endsequence

    a_error_light: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        s_error_request |=> s_light_steady)
        else $error("Error light not held on.");
    a_reset_channel: assert property (@(posedge i_core_clk)
        $rose(i_nrst) |-> o_channel == scs_pkg::CHAN_RESET)
        else $error("Channel not at default after reset.");
    a_entry_flash: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_ce && state_reg == scs_pkg::SCS_IDLE && btn_reg && !lif.busy)
        |=> start_reg && flashes_reg == 2'h1 && state_reg == scs_pkg::SCS_TENS)
        else $error("No entry flash on press.");
    a_tens_latch: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_ce && state_reg == scs_pkg::SCS_TENS && !btn_reg && !over_reg)
        |=> tens_reg == $past(count_reg))
        else $error("Tens digit not latched.");
    a_zero_tens: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (state_reg == scs_pkg::SCS_WAIT2 && $past(state_reg) == scs_pkg::SCS_TENS)
        && $past(count_reg) == 4'h0 |-> tens_reg == 4'h0)
        else $error("Early release gave nonzero tens.");
    a_second_open: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_ce && state_reg == scs_pkg::SCS_WAIT2 && btn_reg)
        |=> start_reg && flashes_reg == 2'h2)
        else $error("No double flash for units phase.");
    a_channel_set: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_ce && state_reg == scs_pkg::SCS_UNITS && !btn_reg && !over_reg)
        |=> o_channel == 7'(tens_reg) * 7'hA + 7'($past(count_reg)) && flashes_reg == 2'h2)
        else $error("Channel not set from digits.");
    a_error_keep: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        state_reg == scs_pkg::SCS_ERROR |-> $stable(o_channel))
        else $error("Channel changed during error.");
    a_report_idle: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        o_report && i_ce |-> $past(state_reg) == scs_pkg::SCS_IDLE ##1 !o_report)
        else $error("Report outside idle or too long.");
endmodule
`default_nettype wire

// >>> hw/scs_pkg.sv
package scs_pkg;
    // Channel numbering and the preset channel used at start.
    localparam int CHAN_W = 7;
    localparam logic [6:0] CHAN_RESET = 7'h23;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    // Core clock rate.
    localparam int CLK_HZ = 200000000;
    // Times in milliseconds; the report period in seconds.
    localparam int FLASH_PERIOD_MS = 500;
    localparam int QUICK_ON_MS = 100;
    localparam int ERROR_ON_MS = 2000;
    localparam int REPORT_S = 180;
    // Derived cycle counts; millisecond counts divide the clock rate by 1000 first.
    localparam longint FLASH_PERIOD_CYC = longint'(CLK_HZ) / 1000 * FLASH_PERIOD_MS;
    localparam longint QUICK_ON_CYC = longint'(CLK_HZ) / 1000 * QUICK_ON_MS;
    localparam longint ERROR_ON_CYC = longint'(CLK_HZ) / 1000 * ERROR_ON_MS;
    localparam longint REPORT_CYC = longint'(CLK_HZ) * REPORT_S;
    localparam int CNT_W = 36;
    typedef enum logic [2:0] {
        SCS_IDLE = 3'b000,
        SCS_ENTRY = 3'b001,
        SCS_TENS = 3'b010,
        SCS_WAIT2 = 3'b011,
        SCS_GAP2 = 3'b100,
        SCS_UNITS = 3'b101,
        SCS_CONFIRM = 3'b110,
        SCS_ERROR = 3'b111
    } scs_state_type;
endpackage

// >>> hw/scs_light_if.sv
`timescale 1ns/1ps
`default_nettype none
// Request from the sequencer to the light pattern generator.
interface scs_light_if;
    logic start;
    logic [1:0] flashes;
    logic hold_on;
    logic busy;
    modport ctrl (output start, output flashes, output hold_on, input busy);
    modport gen (input start, input flashes, input hold_on, output busy);
endinterface
`default_nettype wire

// >>> hw/scs_light_gen.sv
`timescale 1ns/1ps
`default_nettype none
// Plays quick flashes or one long steady pattern on the light.
module scs_light_gen #(
    parameter longint QUICK_CYC = scs_pkg::QUICK_ON_CYC,
    parameter longint LONG_CYC = scs_pkg::ERROR_ON_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    scs_light_if.gen lif,
    output logic o_light
);
    logic [scs_pkg::CNT_W-1:0] cnt_reg;
    logic [2:0] phase_reg;
    logic [1:0] left_reg;

    localparam int W = scs_pkg::CNT_W;
    // Compare values for the end of one quick half-period and of the steady pattern.
    localparam logic [W-1:0] CNT_W_QUICK = W'(QUICK_CYC - 1);
    localparam logic [W-1:0] CNT_W_LONG = W'(LONG_CYC - 1);

    // Each quick flash is on then off for QUICK_CYC; long pattern is steady on.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg <= '0;
            phase_reg <= 3'h0;
            left_reg <= 2'h0;
            o_light <= 1'b0;
        end else if (i_ce) begin
            if (lif.start) begin
                phase_reg <= lif.hold_on ? 3'h3 : 3'h1;
                left_reg <= lif.flashes;
                cnt_reg <= '0;
                o_light <= 1'b1;
            end else if (phase_reg != 3'h0) begin
                cnt_reg <= cnt_reg + 1'b1;
                if (phase_reg == 3'h3 && cnt_reg == CNT_W_LONG) begin
                    phase_reg <= 3'h0;
                    o_light <= 1'b0;
                end else if (phase_reg != 3'h3 && cnt_reg == CNT_W_QUICK) begin
                    cnt_reg <= '0;
                    if (phase_reg == 3'h1) begin
                        phase_reg <= 3'h2;
                        o_light <= 1'b0;
                        left_reg <= left_reg - 2'h1;
                    end else if (left_reg != 2'h0) begin
                        phase_reg <= 3'h1;
                        o_light <= 1'b1;
                    end else begin
                        phase_reg <= 3'h0;
                    end
                end
            end
        end
    end

    assign lif.busy = (phase_reg != 3'h0) || lif.start;
endmodule
`default_nettype wire

// >>> bench/scs_regulator_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Room regulator side: receives the periodic reports from the sensor.
module scs_regulator_model (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_report,
    input wire logic [6:0] i_channel,
    output logic [6:0] o_rx_channel,
    output int o_gap,
    output int o_rx_count
);
    int cnt_reg;

    // Record each report and the cycles since the previous one.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg <= 0;
            o_gap <= 0;
            o_rx_count <= 0;
            o_rx_channel <= 7'h00;
        end else if (i_report) begin
            o_gap <= cnt_reg + 1;
            cnt_reg <= 0;
            o_rx_count <= o_rx_count + 1;
            o_rx_channel <= i_channel;
        end else begin
            cnt_reg <= cnt_reg + 1;
        end
    end
endmodule
`default_nettype wire

// >>> bench/sensor_channel_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench for the channel selection sequencer.
module sensor_channel_select_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic btn = 1'b0;
    logic light;
    logic [6:0] chan;
    logic report;
    logic [6:0] rx_chan;
    logic [6:0] cur;
    logic [6:0] exp_q[$];
    int gap, rx_count, err_count, n_checks, base;
    int rises = 0;
    int run = 0;
    int maxrun = 0;
    logic lp = 1'b0;
    logic clr_max = 1'b0;

    // The clock runs at 200 MHz.
    always #2.5 clk = ~clk;

    scs_sensor_channel_select #(.FLASH_CYC(20), .QUICK_CYC(3), .ERROR_CYC(30),
        .REPORT_CYC(50), .TIMEOUT_CYC(200)) DUT (
        .i_core_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_button(btn),
        .o_light(light), .o_channel(chan), .o_report(report));

    scs_regulator_model partner (
        .i_core_clk(clk), .i_nrst(nrst), .i_report(report), .i_channel(chan),
        .o_rx_channel(rx_chan), .o_gap(gap), .o_rx_count(rx_count));

    // Light monitor: counts rising edges and the longest steady-on run.
    always @(posedge clk) begin
        if (light === 1'b1 && lp !== 1'b1) rises <= rises + 1;
        run <= (light === 1'b1) ? run + 1 : 0;
        if (clr_max) begin
            maxrun <= 0;
        end else if (run > maxrun) begin
            maxrun <= run;
        end
        lp <= light;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Each report must carry the channel noted for it, oldest note first.
    always @(posedge clk) begin
        if (report === 1'b1 && exp_q.size() > 0) chk("channel", chan, exp_q.pop_front());
    end

    task automatic wait_rises(input int n);
        repeat (600) begin
            if (rises - base >= n) break;
            @(posedge clk);
        end
    endtask

    // One full entry; a units value of 10 overflows and 15 never presses again.
    task automatic seq(input int tens, input int units);
        @(posedge report);
        @(posedge report);
        repeat (2) @(posedge clk);
        chk("report gap", gap, 50);
        btn <= 1'b1;
        base = rises;
        repeat (8) @(posedge clk);
        chk("entry flash", rises - base, 1);
        wait_rises(1 + tens);
        repeat (4) @(posedge clk);
        btn <= 1'b0;
        repeat (6) @(posedge clk);
        if (units == 15) begin
            clr_max <= 1'b1;
            @(posedge clk);
            clr_max <= 1'b0;
            repeat (239) @(posedge clk);
            chk("timeout error on", maxrun >= 25, 1);
        end else begin
            btn <= 1'b1;
            base = rises;
            repeat (14) @(posedge clk);
            chk("units start flashes", rises - base, 2);
            wait_rises(2 + units);
            repeat (4) @(posedge clk);
            btn <= 1'b0;
            base = rises;
            clr_max <= 1'b1;
            @(posedge clk);
            clr_max <= 1'b0;
            repeat (39) @(posedge clk);
            if (units > 9) chk("error on", maxrun >= 25, 1);
            else chk("confirm flashes", rises - base, 2);
        end
        if (units <= 9) cur = 7'(tens * 10 + units);
        exp_q.push_back(cur);
    endtask

    // Main sequence: reset, default channel, then entries good and bad.
    initial begin
        err_count = 0;
        n_checks = 0;
        void'($urandom(32'h07B6));
        repeat (6) @(posedge clk);
        chk("reset channel", chan, 7'h23);
        chk("reset light", light, 1'b0);
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        ce <= 1'b0;
        cur = 7'h23;
        exp_q.push_back(cur);
        // With the clock enable low no report may fall due, although one would after 50 cycles.
        repeat (60) @(posedge clk);
        chk("frozen reports", rx_count, 0);
        ce <= 1'b1;
        seq(2, 8);
        seq(0, 7);
        seq(9, 9);
        seq($urandom % 10, $urandom % 10);
        seq(3, 10);
        seq(2, 15);
        seq(0, 0);
        @(posedge report);
        repeat (2) @(posedge clk);
        chk("regulator channel", rx_chan, cur);
        end_sim();
    end

    // Watchdog well beyond the expected run length.
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        end_sim();
    end
endmodule
`default_nettype wire
